//--- hdl/bxd_pkg.sv
// Shared constants and carrier types for the bulk X/Y buffer DMA channel.
// Assumes a single 10 MHz clock and same-clock port and USB-side logic.
package bxd_pkg;

  // Clock rate and the 1 ms frame tick that clocks the timeout.
  localparam int unsigned CLK_PERIOD_NS = 32'h0000_0064;
  localparam int unsigned FRAME_TICK_NS = 32'h000F_4240;
  localparam int unsigned FRAME_CYCLES = FRAME_TICK_NS / CLK_PERIOD_NS;

  // Packet and buffer geometry.
  localparam logic [6:0] PKT_BYTES = 7'h40;
  localparam logic [6:0] PKT_LAST = 7'h3F;

  // Register offsets.
  localparam logic [1:0] OFS_CFG = 2'h0;
  localparam logic [1:0] OFS_TMO = 2'h1;
  localparam logic [1:0] OFS_AUX = 2'h2;

  // Field positions in the channel configuration register.
  localparam int unsigned CFG_RUN = 32'h0000_0007;
  localparam int unsigned CFG_IEN = 32'h0000_0006;
  localparam int unsigned CFG_CEN = 32'h0000_0005;
  localparam int unsigned CFG_XY = 32'h0000_0004;
  localparam int unsigned CFG_DIR = 32'h0000_0003;

  // Field positions in the timeout and status register.
  localparam int unsigned TMO_TEN = 32'h0000_0007;
  localparam int unsigned TMO_VAL_LSB = 32'h0000_0002;
  localparam int unsigned TMO_FLAG = 32'h0000_0001;
  localparam int unsigned TMO_PARTIAL_PACKET_FLAG = 32'h0000_0000;

  // Field positions in the auxiliary status register.
  localparam int unsigned AUX_OVR = 32'h0000_0000;
  localparam int unsigned AUX_UIRQ = 32'h0000_0001;
  localparam int unsigned AUX_HALT = 32'h0000_0002;

  // Port selection codes.
  localparam logic [1:0] PSEL_SER0 = 2'h0;
  localparam logic [1:0] PSEL_SER1 = 2'h1;
  localparam logic [1:0] PSEL_PAR = 2'h2;

  // Channel states.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_IN = 4'h2,
    ST_OUT = 4'h4,
    ST_HALT = 4'h8
  } bxd_state_type;

  // Register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } bxd_bus_req_type;

  // Receive side of the selected port.
  typedef struct packed {
    logic avail;
    logic err;
    logic [7:0] data;
  } bxd_rx_type;

  // Host-to-device bytes arriving from the USB side.
  typedef struct packed {
    logic wr;
    logic end_pkt;
    logic [7:0] data;
  } bxd_usb_out_type;

endpackage

//--- hdl/bxd_frame_timer.sv
// Transaction timeout: 1 ms frame tick divider and a reloadable down counter.
// Assumes arm and load come from logic on the same clock.
`timescale 1ns/1ps
module bxd_frame_timer #(
  parameter int unsigned FRAME_CYCLES = bxd_pkg::FRAME_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic arm_i,
  input wire logic load_i,
  input wire logic [4:0] tval_i,
  output logic expire_o
);
  localparam int unsigned DW = $clog2(FRAME_CYCLES + 1);

  typedef struct packed {
    logic [DW-1:0] div;
    logic tick;
    logic [4:0] cnt;
    logic expire;
  } bxd_tmr_state_type;

  bxd_tmr_state_type st_ff;
  bxd_tmr_state_type nxt_st;

  // Free-running frame tick, reload on each byte, count down per tick.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    nxt_st.expire = 1'b0;
    if (st_ff.div == DW'(FRAME_CYCLES - 1)) begin
      nxt_st.div = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.div = st_ff.div + DW'(1);
    end
    if (!arm_i || load_i) begin
      nxt_st.cnt = tval_i;
    end else if (st_ff.tick) begin
      if (st_ff.cnt <= 5'h01) begin
        nxt_st.cnt = 5'h00;
        nxt_st.expire = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt - 5'h01;
      end
    end
  end

  // State register.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign expire_o = st_ff.expire;
endmodule // bxd_frame_timer

//--- hdl/bxd_dma_core.sv
// Bulk DMA channel moving bytes between a port and X/Y endpoint buffers,
// with the buffer manager that hands buffers to and from the USB side.
// Assumes port and USB-side logic on the same clock; registers on a plain port.
// Function
// - Flows serve both serial channels and the parallel port in every mode.
// - Channel starts continuous transfer when the run bit is written to 1.
// - Inbound, a full 64-byte buffer records count and clears its handoff flag.
// - Buffer manager sends a ready input buffer by its count, toggling X/Y.
// - DMA alternates X and Y buffers without firmware until termination.
// - Inbound timeout with partial data sets timeout, clears overrun, hands off.
// - Buffer manager delivers a partial input packet like a full one.
// - Inbound timeout with both buffers unsent stops, sets timeout and overrun.
// - Serial receive error stops DMA, timeout set, overrun clear, run stays 1.
// - Serial receive error raises the port status interrupt.
// - Outbound, a full 64-byte buffer records count and sets handoff flag.
// - DMA empties each ready output buffer by its count, alternating X/Y.
// - Outbound short buffer is sent, timeout cleared, partial set, irq raised.
// - Outbound timeout with both buffers full stops, timeout set, overrun clear.
// - Timeout reloads on each byte, counts 1 ms ticks, expiry ends the run and returns to idle.
// - With interrupt enabled, falling run bit interrupts firmware.
// - Timeout flag clears on writing 1 or after an outbound short buffer.
`timescale 1ns/1ps
module bxd_dma_core #(
  parameter int unsigned FRAME_CYCLES = bxd_pkg::FRAME_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire bxd_pkg::bxd_bus_req_type bus_i,
  output logic [7:0] rdata_o,
  input wire bxd_pkg::bxd_rx_type rx_i,
  output logic rx_rd_o,
  input wire logic tx_ready_i,
  output logic tx_wr_o,
  output logic [7:0] tx_data_o,
  output logic [1:0] port_sel_o,
  input wire logic usb_in_rd_i,
  input wire logic usb_in_done_i,
  output logic usb_in_ready_o,
  output logic [6:0] usb_in_count_o,
  output logic [7:0] usb_in_data_o,
  input wire bxd_pkg::bxd_usb_out_type usb_out_i,
  output logic usb_out_room_o,
  output logic dma_irq_o,
  output logic uart_status_irq_o
);

  typedef struct packed {
    bxd_pkg::bxd_state_type fsm;
    logic run;
    logic ien;
    logic cen;
    logic dir_out;
    logic [1:0] psel;
    logic ten;
    logic [4:0] tval;
    logic tflag;
    logic partial_packet_flag;
    logic ovr;
    logic uirq;
    logic seen;
    logic [1:0] hand;
    logic [1:0][6:0] bcnt;
    logic dma_xy;
    logic ubm_xy;
    logic [6:0] dma_idx;
    logic [6:0] ubm_idx;
    logic [7:0] rdata;
    logic rx_rd;
    logic tx_wr;
    logic [7:0] tx_data;
    logic [7:0] usb_data;
    logic usb_ready;
    logic [6:0] usb_count;
    logic usb_room;
    logic irq;
  } bxd_core_state_type;

  bxd_core_state_type st_ff;
  bxd_core_state_type nxt_st;
  logic [7:0] buf_mem [0:127];
  logic mem_we;
  logic [6:0] mem_wa;
  logic [7:0] mem_wd;
  logic byte_moved;
  logic tmo_arm;
  logic tmo_expire;

  // Buffer address from X/Y select and byte index.
  function automatic logic [6:0] buf_addr(input logic xy, input logic [6:0] idx);
    buf_addr = {xy, idx[5:0]};
  endfunction

  // Register read mux; the unused offset reads zero.
  function automatic logic [7:0] reg_read(input bxd_core_state_type s,
                                          input logic [1:0] a);
    reg_read = 8'h00;
    case (a)
      bxd_pkg::OFS_CFG: reg_read = {s.run, s.ien, s.cen, s.ubm_xy, s.dir_out, 1'b0, s.psel};
      bxd_pkg::OFS_TMO: reg_read = {s.ten, s.tval, s.tflag, s.partial_packet_flag};
      bxd_pkg::OFS_AUX: reg_read = {5'h00, s.fsm == bxd_pkg::ST_HALT, s.uirq, s.ovr};
      default: reg_read = 8'h00;
    endcase
  endfunction

  // Timeout runs inbound after the first byte, outbound while both buffers wait.
  always_comb begin
    tmo_arm = 1'b0;
    if (st_ff.ten && st_ff.run) begin
      if (st_ff.fsm == bxd_pkg::ST_IN) begin
        tmo_arm = st_ff.seen;
      end else if (st_ff.fsm == bxd_pkg::ST_OUT) begin
        tmo_arm = &st_ff.hand;
      end
    end
  end

  bxd_frame_timer #(
    .FRAME_CYCLES(FRAME_CYCLES)
  ) u_timer (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .arm_i(tmo_arm),
    .load_i(byte_moved),
    .tval_i(st_ff.tval),
    .expire_o(tmo_expire)
  );

  // Buffer manager, DMA engine and register writes; flag sets win over clears.
  always_comb begin
    logic cu;
    logic cd;
    nxt_st = st_ff;
    cu = st_ff.ubm_xy;
    cd = st_ff.dma_xy;
    nxt_st.rdata = 8'h00;
    nxt_st.rx_rd = 1'b0;
    nxt_st.tx_wr = 1'b0;
    nxt_st.irq = 1'b0;
    mem_we = 1'b0;
    mem_wa = 7'h00;
    mem_wd = 8'h00;
    byte_moved = 1'b0;
    // Software clears of sticky flags come first so that a hardware set wins.
    if (bus_i.wr && bus_i.addr == bxd_pkg::OFS_TMO) begin
      nxt_st.ten = bus_i.wdata[bxd_pkg::TMO_TEN];
      nxt_st.tval = bus_i.wdata[bxd_pkg::TMO_VAL_LSB +: 5];
      if (bus_i.wdata[bxd_pkg::TMO_FLAG]) begin
        nxt_st.tflag = 1'b0;
      end
      if (bus_i.wdata[bxd_pkg::TMO_PARTIAL_PACKET_FLAG]) begin
        nxt_st.partial_packet_flag = 1'b0;
      end
    end
    if (bus_i.wr && bus_i.addr == bxd_pkg::OFS_AUX) begin
      if (bus_i.wdata[bxd_pkg::AUX_OVR]) begin
        nxt_st.ovr = 1'b0;
      end
      if (bus_i.wdata[bxd_pkg::AUX_UIRQ]) begin
        nxt_st.uirq = 1'b0;
      end
    end
    if (bus_i.rd) begin
      nxt_st.rdata = reg_read(st_ff, bus_i.addr);
    end
    // Buffer manager, inbound: drain ready buffers, also after the run has ended.
    if (st_ff.seen && !st_ff.dir_out) begin
      if (usb_in_rd_i && !st_ff.hand[cu]) begin
        nxt_st.usb_data = buf_mem[buf_addr(cu, st_ff.ubm_idx)];
        nxt_st.ubm_idx = st_ff.ubm_idx + 7'h01;
      end
      if (usb_in_done_i && !st_ff.hand[cu]) begin
        nxt_st.hand[cu] = 1'b1;
        nxt_st.ubm_xy = ~cu;
        nxt_st.ubm_idx = 7'h00;
      end
    end
    // Buffer manager, outbound: fill an empty buffer and hand it to the DMA.
    if (st_ff.run && st_ff.dir_out && !st_ff.hand[cu]) begin
      if (usb_out_i.wr) begin
        mem_we = 1'b1;
        mem_wa = buf_addr(cu, st_ff.ubm_idx);
        mem_wd = usb_out_i.data;
        nxt_st.ubm_idx = st_ff.ubm_idx + 7'h01;
        if (st_ff.ubm_idx == bxd_pkg::PKT_LAST) begin
          nxt_st.bcnt[cu] = bxd_pkg::PKT_BYTES;
          nxt_st.hand[cu] = 1'b1;
          nxt_st.ubm_xy = ~cu;
          nxt_st.ubm_idx = 7'h00;
        end
      end else if (usb_out_i.end_pkt) begin
        nxt_st.bcnt[cu] = st_ff.ubm_idx;
        nxt_st.hand[cu] = 1'b1;
        nxt_st.ubm_xy = ~cu;
        nxt_st.ubm_idx = 7'h00;
      end
    end
    // DMA engine.
    case (st_ff.fsm)
      bxd_pkg::ST_IN: begin
        if (rx_i.err && st_ff.psel != bxd_pkg::PSEL_PAR) begin
          nxt_st.fsm = bxd_pkg::ST_HALT;
          nxt_st.tflag = 1'b1;
          nxt_st.ovr = 1'b0;
          nxt_st.uirq = 1'b1;
        end else if (tmo_expire) begin
          nxt_st.tflag = 1'b1;
          nxt_st.run = 1'b0;
          nxt_st.fsm = bxd_pkg::ST_IDLE;
          if (st_ff.hand == 2'b00) begin
            nxt_st.ovr = 1'b1;
          end else begin
            nxt_st.ovr = 1'b0;
            if (st_ff.dma_idx != 7'h00) begin
              nxt_st.bcnt[cd] = st_ff.dma_idx;
              nxt_st.hand[cd] = 1'b0;
              nxt_st.dma_xy = ~cd;
              nxt_st.dma_idx = 7'h00;
            end
          end
        end else if (st_ff.cen && st_ff.hand[cd] && rx_i.avail && !st_ff.rx_rd) begin
          mem_we = 1'b1;
          mem_wa = buf_addr(cd, st_ff.dma_idx);
          mem_wd = rx_i.data;
          nxt_st.rx_rd = 1'b1;
          nxt_st.seen = 1'b1;
          byte_moved = 1'b1;
          nxt_st.dma_idx = st_ff.dma_idx + 7'h01;
          if (st_ff.dma_idx == bxd_pkg::PKT_LAST) begin
            nxt_st.bcnt[cd] = bxd_pkg::PKT_BYTES;
            nxt_st.hand[cd] = 1'b0;
            nxt_st.dma_xy = ~cd;
            nxt_st.dma_idx = 7'h00;
          end
        end
      end
      bxd_pkg::ST_OUT: begin
        if (tmo_expire) begin
          nxt_st.tflag = 1'b1;
          nxt_st.ovr = 1'b0;
          nxt_st.run = 1'b0;
          nxt_st.fsm = bxd_pkg::ST_IDLE;
        end else if (st_ff.cen && st_ff.hand[cd] && !st_ff.tx_wr) begin
          if (st_ff.bcnt[cd] == 7'h00) begin
            nxt_st.hand[cd] = 1'b0;
            nxt_st.dma_xy = ~cd;
            nxt_st.tflag = 1'b0;
            nxt_st.partial_packet_flag = 1'b1;
            nxt_st.run = 1'b0;
            nxt_st.fsm = bxd_pkg::ST_IDLE;
          end else if (tx_ready_i) begin
            nxt_st.tx_wr = 1'b1;
            nxt_st.tx_data = buf_mem[buf_addr(cd, st_ff.dma_idx)];
            byte_moved = 1'b1;
            nxt_st.dma_idx = st_ff.dma_idx + 7'h01;
            if (st_ff.dma_idx + 7'h01 == st_ff.bcnt[cd]) begin
              nxt_st.hand[cd] = 1'b0;
              nxt_st.dma_xy = ~cd;
              nxt_st.dma_idx = 7'h00;
              if (st_ff.bcnt[cd] < bxd_pkg::PKT_BYTES) begin
                nxt_st.tflag = 1'b0;
                nxt_st.partial_packet_flag = 1'b1;
                nxt_st.run = 1'b0;
                nxt_st.fsm = bxd_pkg::ST_IDLE;
              end
            end
          end
        end
      end
      bxd_pkg::ST_IDLE: begin
        nxt_st.fsm = bxd_pkg::ST_IDLE;
      end
      bxd_pkg::ST_HALT: begin
        nxt_st.fsm = bxd_pkg::ST_HALT;
      end
      default: begin
        nxt_st.fsm = bxd_pkg::ST_IDLE;
      end
    endcase
    // Configuration write comes last; a new run starts a fresh X/Y cycle.
    if (bus_i.wr && bus_i.addr == bxd_pkg::OFS_CFG) begin
      nxt_st.run = bus_i.wdata[bxd_pkg::CFG_RUN];
      nxt_st.ien = bus_i.wdata[bxd_pkg::CFG_IEN];
      nxt_st.cen = bus_i.wdata[bxd_pkg::CFG_CEN];
      nxt_st.psel = bus_i.wdata[1:0];
      if (!bus_i.wdata[bxd_pkg::CFG_RUN]) begin
        nxt_st.fsm = bxd_pkg::ST_IDLE;
      end else if (!st_ff.run) begin
        nxt_st.dir_out = bus_i.wdata[bxd_pkg::CFG_DIR];
        nxt_st.fsm = bus_i.wdata[bxd_pkg::CFG_DIR] ? bxd_pkg::ST_OUT : bxd_pkg::ST_IN;
        nxt_st.hand = bus_i.wdata[bxd_pkg::CFG_DIR] ? 2'b00 : 2'b11;
        nxt_st.dma_xy = bus_i.wdata[bxd_pkg::CFG_XY];
        nxt_st.ubm_xy = bus_i.wdata[bxd_pkg::CFG_XY];
        nxt_st.dma_idx = 7'h00;
        nxt_st.ubm_idx = 7'h00;
        nxt_st.seen = 1'b0;
      end
    end
    // Completion interrupt on the falling edge of the run bit.
    nxt_st.irq = st_ff.run && !nxt_st.run && st_ff.ien;
    // USB-side views of the buffer currently owned by the buffer manager.
    nxt_st.usb_ready = nxt_st.seen && !nxt_st.dir_out && !nxt_st.hand[nxt_st.ubm_xy];
    nxt_st.usb_count = nxt_st.bcnt[nxt_st.ubm_xy];
    nxt_st.usb_room = nxt_st.run && nxt_st.dir_out && !nxt_st.hand[nxt_st.ubm_xy];
  end

  // Endpoint buffer RAM, X in the low half and Y in the high half.
  always_ff @(posedge mclk_i) begin
    if (mem_we) begin
      buf_mem[mem_wa] <= mem_wd;
    end
  end

  // State register.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
      st_ff.fsm <= bxd_pkg::ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state register.
  assign rdata_o = st_ff.rdata;
  assign rx_rd_o = st_ff.rx_rd;
  assign tx_wr_o = st_ff.tx_wr;
  assign tx_data_o = st_ff.tx_data;
  assign port_sel_o = st_ff.psel;
  assign usb_in_ready_o = st_ff.usb_ready;
  assign usb_in_count_o = st_ff.usb_count;
  assign usb_in_data_o = st_ff.usb_data;
  assign usb_out_room_o = st_ff.usb_room;
  assign dma_irq_o = st_ff.irq;
  assign uart_status_irq_o = st_ff.uirq;
endmodule // bxd_dma_core

//--- verif/bxd_dma_core_properties.sv
// Concurrent checks on the ports of the bulk X/Y buffer DMA channel.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
module bxd_dma_core_properties #(
  parameter int unsigned FRAME_CYCLES = bxd_pkg::FRAME_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire bxd_pkg::bxd_bus_req_type bus_i,
  input wire bxd_pkg::bxd_rx_type rx_i,
  input wire logic rx_rd_o,
  input wire logic tx_ready_i,
  input wire logic tx_wr_o,
  input wire logic [1:0] port_sel_o,
  input wire logic usb_in_ready_o,
  input wire logic [6:0] usb_in_count_o,
  input wire logic dma_irq_o,
  input wire logic uart_status_irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // A receiver error is followed by four quiet cycles on the completion interrupt.
  sequence s_no_irq4;
    !dma_irq_o [*4];
  endsequence

  // Port-side pacing and the causes of each pop and push.
  chk_rx_spacing: assert property (rx_rd_o |=> !rx_rd_o)
    else $error("receive pops on two cycles in a row");
  chk_rx_cause: assert property (rx_rd_o |-> $past(rx_i.avail))
    else $error("receive pop without a byte present");
  chk_tx_cause: assert property (tx_wr_o |-> $past(tx_ready_i) && !$past(tx_wr_o))
    else $error("transmit push without port ready");
  // Completion interrupt shape and the IN byte count range.
  chk_irq_pulse: assert property (dma_irq_o |=> !dma_irq_o)
    else $error("completion interrupt longer than one cycle");
  chk_in_count: assert property (usb_in_ready_o |-> usb_in_count_o inside {[7'h01:7'h40]})
    else $error("ready IN buffer with a bad byte count");
  // Serial receiver error handling.
  chk_uerr_quiet: assert property ($rose(uart_status_irq_o) |-> s_no_irq4)
    else $error("completion interrupt after a receiver error");
  chk_uerr_cause: assert property ($rose(uart_status_irq_o) |->
      $past(rx_i.err) && $past(port_sel_o) != bxd_pkg::PSEL_PAR)
    else $error("status interrupt without a serial receiver error");
  chk_uerr_hold: assert property (uart_status_irq_o && !(bus_i.wr &&
      bus_i.addr == bxd_pkg::OFS_AUX && bus_i.wdata[bxd_pkg::AUX_UIRQ]) |=> uart_status_irq_o)
    else $error("status interrupt dropped without a clear");
endmodule // bxd_dma_core_properties

bind bxd_dma_core bxd_dma_core_properties #(.FRAME_CYCLES(FRAME_CYCLES)) bxd_dma_core_properties_i (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rx_i(rx_i), .rx_rd_o(rx_rd_o),
  .tx_ready_i(tx_ready_i), .tx_wr_o(tx_wr_o), .port_sel_o(port_sel_o),
  .usb_in_ready_o(usb_in_ready_o), .usb_in_count_o(usb_in_count_o), .dma_irq_o(dma_irq_o),
  .uart_status_irq_o(uart_status_irq_o));

//--- verif/bxd_port_model.sv
// Port-side stand-in: a receive byte source and a transmit side that can stall.
// Assumes one clock; received bytes are a running count from zero.
`timescale 1ns/1ps
module bxd_port_model (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] fill_i,
  input wire logic go_i,
  input wire logic err_i,
  input wire logic stall_i,
  input wire logic rx_rd_i,
  output bxd_pkg::bxd_rx_type rx_o,
  output logic tx_ready_o
);
  logic [7:0] seq_ff;
  logic [7:0] left_ff;

  // Each pop advances the byte at the edge that ends it; go loads a byte budget.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq_ff <= 8'h00;
      left_ff <= 8'h00;
    end else if (go_i) begin
      left_ff <= fill_i;
    end else if (rx_rd_i && left_ff != 8'h00) begin
      seq_ff <= seq_ff + 8'h01;
      left_ff <= left_ff - 8'h01;
    end
  end

  // Once drained, the data lines show the inverse so stale bytes never match.
  assign rx_o = '{avail: left_ff != 8'h00, err: err_i,
                  data: (left_ff != 8'h00) ? seq_ff : ~seq_ff};
  assign tx_ready_o = !stall_i;
endmodule // bxd_port_model

//--- verif/bxd_dma_core_tb.sv
// Self-checking bench for the bulk X/Y buffer DMA channel.
// Assumes the port model and the bound checker are compiled before it.
`timescale 1ns/1ps
module bxd_dma_core_tb;
  typedef struct packed {logic [1:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] p;} bxd_row_type;
  bxd_row_type rows [6] = '{{2'h0, 8'h61, 8'h61, 2'h1}, {2'h0, 8'h6A, 8'h62, 2'h2},
    {2'h0, 8'h64, 8'h60, 2'h0}, {2'h1, 8'hFF, 8'hFC, 2'h0}, {2'h2, 8'hFF, 8'h00, 2'h0},
    {2'h3, 8'hFF, 8'h00, 2'h0}};
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  bxd_pkg::bxd_bus_req_type bus = '0;
  bxd_pkg::bxd_rx_type rx;
  bxd_pkg::bxd_usb_out_type uo = '0;
  logic [7:0] rdata, txd, ind, fill = 8'h00, ub = 8'h00, oseq = 8'h00, iseq = 8'h00;
  logic [6:0] icnt;
  logic [1:0] psel;
  logic rx_rd, tx_rdy, tx_wr, uin_rdy, room, irq, uirq;
  logic uin_rd = 1'b0, uin_done = 1'b0, go = 1'b0, err = 1'b0, stall = 1'b0;
  int error_cnt = 0, checks = 0, irqs = 0, txn = 0;

  bxd_dma_core #(.FRAME_CYCLES(20)) bxd_dma_core_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .bus_i(bus), .rdata_o(rdata), .rx_i(rx), .rx_rd_o(rx_rd), .tx_ready_i(tx_rdy),
    .tx_wr_o(tx_wr), .tx_data_o(txd), .port_sel_o(psel), .usb_in_rd_i(uin_rd),
    .usb_in_done_i(uin_done), .usb_in_ready_o(uin_rdy), .usb_in_count_o(icnt),
    .usb_in_data_o(ind), .usb_out_i(uo), .usb_out_room_o(room), .dma_irq_o(irq),
    .uart_status_irq_o(uirq));
  bxd_port_model bxd_port_model_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .fill_i(fill),
    .go_i(go), .err_i(err), .stall_i(stall), .rx_rd_i(rx_rd), .rx_o(rx), .tx_ready_o(tx_rdy));

  // Clock at 10 MHz.
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end

  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g, input logic [7:0] m);
    checks++;
    if ((g & m) !== (e & m)) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e & m, g & m);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk_i);
    bus <= '0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m, input string nm);
    @(posedge mclk_i);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk_i);
    bus <= '0;
    @(negedge mclk_i);
    cmp(nm, e, rdata, m);
  endtask

  task automatic feed(input logic [7:0] n);
    @(posedge mclk_i);
    fill <= n;
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
  endtask

  // Host side of one IN buffer: wait, check the count, read every byte, release it.
  task automatic take(input logic [6:0] n);
    int i;
    i = 0;
    while (uin_rdy !== 1'b1 && i < 600) begin
      @(negedge mclk_i);
      i++;
    end
    cmp("in_count", {1'b1, n}, {uin_rdy, icnt}, 8'hFF);
    for (i = 0; i < n; i++) begin
      @(posedge mclk_i);
      uin_rd <= 1'b1;
      @(posedge mclk_i);
      uin_rd <= 1'b0;
      @(negedge mclk_i);
      cmp("in_data", iseq, ind, 8'hFF);
      iseq++;
    end
    @(posedge mclk_i);
    uin_done <= 1'b1;
    @(posedge mclk_i);
    uin_done <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask

  // Host side of OUT: one byte per room check, then an optional short-packet close.
  task automatic put(input int n, input logic endp);
    int i, k;
    for (i = 0; i < n; i++) begin
      k = 0;
      @(negedge mclk_i);
      while (room !== 1'b1 && k < 800) begin
        @(negedge mclk_i);
        k++;
      end
      @(posedge mclk_i);
      uo <= '{wr: 1'b1, end_pkt: 1'b0, data: ub};
      ub++;
      @(posedge mclk_i);
      uo <= '0;
    end
    if (endp) begin
      @(posedge mclk_i);
      uo <= '{wr: 1'b0, end_pkt: 1'b1, data: 8'h00};
      @(posedge mclk_i);
      uo <= '0;
    end
  endtask

  // Counts completion interrupts and checks every byte pushed to the port.
  always @(posedge mclk_i) begin
    if (irq === 1'b1) irqs++;
    if (tx_wr === 1'b1) begin
      cmp("tx_data", oseq, txd, 8'hFF);
      oseq++;
      txn++;
    end
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge mclk_i);
    error_cnt++;
    stop_test();
  end

  // Reset, register rows, then IN, overrun, receiver error and OUT cases.
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(negedge mclk_i);
    cmp("outputs", 8'h00, {irq, uirq, uin_rdy, room, tx_wr, rx_rd, psel}, 8'hFF);
    for (int i = 0; i < 3; i++) rd(i[1:0], 8'h00, 8'hFF, "reset_value");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, 8'hFF, "reg_row");
      cmp("port_sel", {6'h00, rows[i].p}, {6'h00, psel}, 8'hFF);
    end
    wr(bxd_pkg::OFS_TMO, 8'h88);
    feed(8'd130);
    wr(bxd_pkg::OFS_CFG, 8'hE0);
    take(7'h40);
    take(7'h40);
    take(7'h02);
    rd(bxd_pkg::OFS_TMO, 8'h8A, 8'hFF, "tmo_partial");
    rd(bxd_pkg::OFS_AUX, 8'h00, 8'h01, "ovr_partial");
    rd(bxd_pkg::OFS_CFG, 8'h00, 8'h80, "run_partial");
    cmp("irq_count", 8'd1, irqs[7:0], 8'hFF);
    wr(bxd_pkg::OFS_TMO, 8'h88);
    rd(bxd_pkg::OFS_TMO, 8'h8A, 8'hFF, "tmo_w0");
    wr(bxd_pkg::OFS_TMO, 8'h8A);
    rd(bxd_pkg::OFS_TMO, 8'h88, 8'hFF, "tmo_w1");
    feed(8'd140);
    wr(bxd_pkg::OFS_CFG, 8'hE0);
    repeat (500) @(posedge mclk_i);
    rd(bxd_pkg::OFS_TMO, 8'h8A, 8'hFF, "tmo_overrun");
    rd(bxd_pkg::OFS_AUX, 8'h01, 8'h01, "ovr_overrun");
    cmp("irq_count", 8'd2, irqs[7:0], 8'hFF);
    wr(bxd_pkg::OFS_TMO, 8'h8A);
    wr(bxd_pkg::OFS_AUX, 8'h01);
    wr(bxd_pkg::OFS_CFG, 8'hE1);
    repeat (4) @(posedge mclk_i);
    err <= 1'b1;
    @(posedge mclk_i);
    err <= 1'b0;
    repeat (4) @(negedge mclk_i);
    cmp("uart_irq", 8'h01, {7'h00, uirq}, 8'hFF);
    rd(bxd_pkg::OFS_CFG, 8'h80, 8'h80, "run_err");
    rd(bxd_pkg::OFS_TMO, 8'h8A, 8'hFF, "tmo_err");
    rd(bxd_pkg::OFS_AUX, 8'h06, 8'h07, "aux_err");
    cmp("irq_count", 8'd2, irqs[7:0], 8'hFF);
    wr(bxd_pkg::OFS_CFG, 8'h61);
    repeat (3) @(posedge mclk_i);
    cmp("irq_count", 8'd3, irqs[7:0], 8'hFF);
    wr(bxd_pkg::OFS_TMO, 8'h8A);
    wr(bxd_pkg::OFS_AUX, 8'h02);
    wr(bxd_pkg::OFS_CFG, 8'hEA);
    put(67, 1'b1);
    repeat (200) @(posedge mclk_i);
    cmp("tx_count", 8'd67, txn[7:0], 8'hFF);
    rd(bxd_pkg::OFS_TMO, 8'h89, 8'hFF, "tmo_short");
    rd(bxd_pkg::OFS_CFG, 8'h00, 8'h80, "run_short");
    cmp("irq_count", 8'd4, irqs[7:0], 8'hFF);
    wr(bxd_pkg::OFS_TMO, 8'h89);
    stall <= 1'b1;
    wr(bxd_pkg::OFS_CFG, 8'hEA);
    put(128, 1'b0);
    repeat (150) @(posedge mclk_i);
    stall <= 1'b0;
    rd(bxd_pkg::OFS_TMO, 8'h8A, 8'hFF, "tmo_busy");
    rd(bxd_pkg::OFS_AUX, 8'h00, 8'h01, "ovr_busy");
    cmp("irq_count", 8'd5, irqs[7:0], 8'hFF);
    repeat (20) @(posedge mclk_i);
    cmp("tx_count", 8'd67, txn[7:0], 8'hFF);
    stop_test();
  end
endmodule // bxd_dma_core_tb
